//--- logic/bgs_board_glue.sv
// board glue: status indicators, grant chain, board select, drive select
// Function
// RULE_01 - at power-up run self-test: second and third indicators lit, first dark
// RULE_02 - self-test passed, no error: only first indicator lit
// RULE_03 - self-test clock or memory fault: only second indicator lit
// RULE_04 - drive error such as write protect or not ready: only third lit
// RULE_05 - controller error such as crc, overrun, io: second and third lit
// RULE_06 - bus mastership arbitrated by grant daisy chain, upper card wins
// RULE_07 - grant passes down the chain; upper card can suspend a lower one
// RULE_08 - card decodes a 32-bit window, default base 100 hex to 120 hex
// RULE_09 - board select goes low only on the programmed address pattern
// RULE_10 - integrator gives each card a distinct select pattern
// RULE_11 - drive select line chosen from drive number in command word two
// RULE_12 - two-bit drive id maps directly: 00 first drive, 01 second, etc
// RULE_13 - drive bus only while granted; hold grant out off while requesting
`timescale 1ns/100ps
module bgs_board_glue
  import bgs_pkg::*;
#(
  parameter logic [bgs_pkg::ADDR_W-1:0] SEL_PATTERN = bgs_pkg::SEL_PATTERN_DEF
)
(
  // clock and reset
  input  wire logic                        clock_in,
  input  wire logic                        rst_in,
  // self-test and error events from the controller core
  input  wire logic                        selftest_done_in,
  input  wire logic                        selftest_fault_in,
  input  wire logic                        drive_error_in,
  input  wire logic                        ctrl_error_in,
  input  wire logic                        error_clear_in,
  // status indicators, high means lit
  output logic                             status_led_first_out,
  output logic                             status_led_second_out,
  output logic                             status_led_third_out,
  // grant daisy chain
  input  wire logic                        bus_request_in,
  input  wire logic                        bus_grant_in_n_in,
  output logic                             bus_grant_out_n_out,
  output logic                             bus_owned_out,
  output logic                             bus_drive_en_out,
  // host address decode
  input  wire logic [bgs_pkg::ADDR_W-1:0]  host_addr_in,
  output logic                             board_select_n_out,
  // drive select
  input  wire logic [bgs_pkg::CMD_W-1:0]   cmd_word2_in,
  input  wire logic                        cmd_load_in,
  output logic [bgs_pkg::DRIVES-1:0]       drive_select_out
);

  import bgs_pkg::*;

  // status state machine
  bgs_status_e state_reg;
  bgs_status_e state_next;
  logic [2:0]  led_reg;
  logic [2:0]  led_next;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      BGS_ST_TEST:
      begin
        if (selftest_fault_in)
          state_next = BGS_ST_SELF_FAIL; // RULE_03
        else if (selftest_done_in)
          state_next = BGS_ST_OK; // RULE_02
      end
      BGS_ST_OK, BGS_ST_DRIVE_ERR, BGS_ST_CTRL_ERR:
      begin
        // a new error in the clear cycle wins over the clear, except a drive error while in the controller-error state
        if (ctrl_error_in)
          state_next = BGS_ST_CTRL_ERR; // RULE_05
        else if (drive_error_in && state_reg != BGS_ST_CTRL_ERR)
          state_next = BGS_ST_DRIVE_ERR; // RULE_04
        else if (error_clear_in)
          state_next = BGS_ST_OK;
      end
      // a failed self-test is only left by reset
      BGS_ST_SELF_FAIL: state_next = BGS_ST_SELF_FAIL;
      default:          state_next = BGS_ST_TEST;
    endcase
    case (state_next)
      BGS_ST_TEST:      led_next = LED_TEST; // RULE_01
      BGS_ST_OK:        led_next = LED_OK; // RULE_02
      BGS_ST_SELF_FAIL: led_next = LED_SELF_FAIL; // RULE_03
      BGS_ST_DRIVE_ERR: led_next = LED_DRIVE_ERR; // RULE_04
      BGS_ST_CTRL_ERR:  led_next = LED_CTRL_ERR; // RULE_05
      default:          led_next = LED_TEST;
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      state_reg <= BGS_ST_TEST;
      led_reg   <= LED_TEST; // RULE_01
    end
    else
    begin
      state_reg <= state_next;
      led_reg   <= led_next;
    end
  end

  assign status_led_first_out  = led_reg[0];
  assign status_led_second_out = led_reg[1];
  assign status_led_third_out  = led_reg[2];

  // grant chain
  logic grant_in;
  logic owned_reg;
  logic owned_next;
  logic grant_out_n_reg;
  logic grant_out_n_next;

  assign grant_in = !bus_grant_in_n_in;

  always_comb
  begin
    // ownership ends on the clock edge after the upper card pulls grant away
    owned_next       = bus_request_in && grant_in; // RULE_06
    // pass grant down only when idle; a requesting card blocks lower ones
    grant_out_n_next = !(grant_in && !bus_request_in && !owned_reg); // RULE_07
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      owned_reg       <= 1'b0;
      grant_out_n_reg <= 1'b1;
    end
    else
    begin
      owned_reg       <= owned_next; // RULE_13
      grant_out_n_reg <= grant_out_n_next; // RULE_13
    end
  end

  assign bus_owned_out       = owned_reg;
  assign bus_drive_en_out    = owned_reg;
  assign bus_grant_out_n_out = grant_out_n_reg;

  // board select through the lookup memory
  bgs_sel_if sel_bus ();

  assign sel_bus.addr = host_addr_in;

  bgs_select_rom #(
    .PATTERN (SEL_PATTERN)
  ) u_select_rom (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .sel      (sel_bus.rom)
  );

  assign board_select_n_out = sel_bus.select_n; // RULE_08

  // drive select, one-hot from the low bits of command word two
  logic [DRIVES-1:0]   drv_sel_reg;
  logic [DRIVES-1:0]   drv_sel_next;
  logic [DRV_ID_W-1:0] drv_id;

  assign drv_id = cmd_word2_in[DRV_ID_LSB +: DRV_ID_W];

  always_comb
  begin
    drv_sel_next = drv_sel_reg;
    if (cmd_load_in)
      drv_sel_next = DRIVES'(1) << drv_id; // RULE_11 RULE_12
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      drv_sel_reg <= DRV_SEL_RESET;
    else
      drv_sel_reg <= drv_sel_next;
  end

  assign drive_select_out = drv_sel_reg;

  // checks
  a_test_leds : assert property (@(posedge clock_in)
    $fell(rst_in) |-> {status_led_third_out, status_led_second_out,
    status_led_first_out} == 3'h6) // RULE_01
    else $error("self-test indicators wrong after reset");
  a_pass_leds : assert property (@(posedge clock_in) disable iff (rst_in)
    (state_reg == BGS_ST_TEST && selftest_done_in && !selftest_fault_in) |=>
    {status_led_third_out, status_led_second_out, status_led_first_out} == 3'h1) // RULE_02
    else $error("pass indicators wrong");
  a_fail_leds : assert property (@(posedge clock_in) disable iff (rst_in)
    (state_reg == BGS_ST_TEST && selftest_fault_in) |=>
    {status_led_third_out, status_led_second_out, status_led_first_out} == 3'h2
    ##1 status_led_second_out && !status_led_first_out) // RULE_03
    else $error("self-test fault indicators wrong");
  a_drive_leds : assert property (@(posedge clock_in) disable iff (rst_in)
    (state_reg == BGS_ST_OK && drive_error_in && !ctrl_error_in) |=>
    {status_led_third_out, status_led_second_out, status_led_first_out} == 3'h4) // RULE_04
    else $error("drive error indicators wrong");
  a_ctrl_leds : assert property (@(posedge clock_in) disable iff (rst_in)
    (state_reg != BGS_ST_TEST && state_reg != BGS_ST_SELF_FAIL && ctrl_error_in) |=>
    {status_led_third_out, status_led_second_out, status_led_first_out} == 3'h6) // RULE_05
    else $error("controller error indicators wrong");
  a_grant_block : assert property (@(posedge clock_in) disable iff (rst_in)
    (bus_request_in || owned_reg) |=> bus_grant_out_n_out) // RULE_13
    else $error("grant passed down while requesting");
  a_grant_pass : assert property (@(posedge clock_in) disable iff (rst_in)
    (grant_in && !bus_request_in && !owned_reg) |=> !bus_grant_out_n_out) // RULE_07
    else $error("idle card withheld grant");
  a_own_needs_grant : assert property (@(posedge clock_in) disable iff (rst_in)
    bus_drive_en_out |-> $past(grant_in)) // RULE_06
    else $error("bus driven without grant");
  a_drive_onehot : assert property (@(posedge clock_in) disable iff (rst_in)
    cmd_load_in |=> drive_select_out == (4'h1 << $past(drv_id))) // RULE_12
    else $error("drive select does not match drive id");

  c_pass : cover property (@(posedge clock_in) disable iff (rst_in)
    state_reg == BGS_ST_TEST ##1 state_reg == BGS_ST_OK);
  c_ctrl_err : cover property (@(posedge clock_in) disable iff (rst_in)
    state_reg == BGS_ST_CTRL_ERR);
  c_suspend : cover property (@(posedge clock_in) disable iff (rst_in)
    owned_reg ##1 !owned_reg && bus_request_in);
  c_select : cover property (@(posedge clock_in) disable iff (rst_in)
    !board_select_n_out);

endmodule

//--- logic/bgs_pkg.sv
// constants and types shared by the board glue design files
package bgs_pkg;

  // host address lines 3 to 10 feed the select lookup
  localparam int          ADDR_W          = 8;
  localparam int          ROM_DEPTH       = 256;
  // default select pattern: all zero except address line 5 (bit 2 of lines 3..10)
  localparam logic [7:0]  SEL_PATTERN_DEF = 8'h04;
  // serial bit-io window occupied by the card
  localparam logic [11:0] WINDOW_BASE     = 12'h100;
  localparam logic [11:0] WINDOW_END      = 12'h120;
  localparam int          WINDOW_BITS     = 32;

  // drive select
  localparam int          DRIVES          = 4;
  localparam int          CMD_W           = 16;
  localparam int          DRV_ID_LSB      = 0;
  localparam int          DRV_ID_W        = 2;
  localparam logic [3:0]  DRV_SEL_RESET   = 4'h0;

  // status indicator patterns {third, second, first}
  localparam logic [2:0]  LED_TEST        = 3'h6;
  localparam logic [2:0]  LED_OK          = 3'h1;
  localparam logic [2:0]  LED_SELF_FAIL   = 3'h2;
  localparam logic [2:0]  LED_DRIVE_ERR   = 3'h4;
  localparam logic [2:0]  LED_CTRL_ERR    = 3'h6;

  typedef enum logic [2:0] {
    BGS_ST_TEST,
    BGS_ST_OK,
    BGS_ST_SELF_FAIL,
    BGS_ST_DRIVE_ERR,
    BGS_ST_CTRL_ERR
  } bgs_status_e;

endpackage

//--- logic/bgs_sel_if.sv
// carrier between the top module and the select lookup memory
`timescale 1ns/100ps
interface bgs_sel_if;
  logic [bgs_pkg::ADDR_W-1:0] addr;
  logic                       select_n;
  modport top (output addr, input select_n);
  modport rom (input addr, output select_n);
endinterface

//--- logic/bgs_select_rom.sv
// board select lookup memory, one bit per host address pattern
`timescale 1ns/100ps
module bgs_select_rom
  import bgs_pkg::*;
#(
  parameter logic [ADDR_W-1:0] PATTERN = SEL_PATTERN_DEF
)
(
  // clock and reset
  input  wire logic clock_in,
  input  wire logic rst_in,
  // lookup port
  bgs_sel_if.rom    sel
);

  logic [ROM_DEPTH-1:0] table_bits;
  logic                 select_n_reg;
  logic                 select_n_next;

  // contents built as a constant table so a new pattern needs no reprogramming step
  genvar i;
  generate
    for (i = 0; i < ROM_DEPTH; i++)
    begin : g_entry
      // genvars take no part-select, so the entry index gets its own sized constant
      localparam logic [ADDR_W-1:0] ENTRY = ADDR_W'(i);
      assign table_bits[i] = (ENTRY == PATTERN) ? 1'b0 : 1'b1; // RULE_09
    end
  endgenerate

  always_comb
  begin
    select_n_next = table_bits[sel.addr]; // RULE_08
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      select_n_reg <= 1'b1;
    else
      select_n_reg <= select_n_next;
  end

  assign sel.select_n = select_n_reg;

  a_select_low_match : assert property (@(posedge clock_in) disable iff (rst_in)
    ##1 !rst_in ##0 ($past(sel.addr) == PATTERN) |-> !sel.select_n) // RULE_09
    else $error("board select not low on programmed pattern");
  a_select_high_else : assert property (@(posedge clock_in) disable iff (rst_in)
    ##1 ($past(sel.addr) != PATTERN && !$past(rst_in)) |-> sel.select_n) // RULE_09
    else $error("board select low on foreign pattern");

endmodule

//--- testbench/bgs_upper_card_model.sv
// upper card model that drives the grant chain input of the card below it
`timescale 1ns/100ps
module bgs_upper_card_model
(
  // clock and reset
  input  wire logic clock_in,
  input  wire logic rst_in,
  // upper card wants the bus for itself
  input  wire logic upper_req_in,
  // grant passed down to the card below, active low
  output logic      bus_grant_n_out
);
  logic grant_n_reg;
  logic grant_n_next;
  // grant withheld during reset too, so no card below can start early
  always_comb grant_n_next = rst_in | upper_req_in;
  always_ff @(posedge clock_in) grant_n_reg <= grant_n_next;
  assign bus_grant_n_out = grant_n_reg;
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the board glue block
`timescale 1ns/100ps
module tb_top;
  import bgs_pkg::*;
  typedef struct packed
  {
    logic [7:0]  addr;
    logic [15:0] cmd;
    logic        sel_n;
    logic [3:0]  drv;
  } bgs_row_s;
  logic        clock_in   = 1'b0;
  logic        rst_in     = 1'b1;
  // events as {done, fault, drive, ctrl, clear}
  logic [4:0]  ev_bits    = 5'h0;
  logic        req        = 1'b0;
  logic        upper_req  = 1'b0;
  logic [7:0]  addr       = 8'h0;
  logic [15:0] cmd        = 16'h0;
  logic        load       = 1'b0;
  logic        led1, led2, led3, gout_n, gin_n, owned, drv_en, sel_n;
  logic [3:0]  drv;
  int          n_mismatch = 0;
  int          compares   = 0;
  int          cycles     = 0;
  // upper command bits set in all rows but the second, so a decoder reading the wrong field shows up
  bgs_row_s    rows [4]   = '{'{8'h04, 16'hfff0, 1'b0, 4'h1},
                              '{8'h05, 16'h0001, 1'b1, 4'h2},
                              '{8'h00, 16'h8002, 1'b1, 4'h4},
                              '{8'hfb, 16'h7ff3, 1'b1, 4'h8}};

  bgs_board_glue bgs_board_glue_i (
    .clock_in(clock_in), .rst_in(rst_in),
    .selftest_done_in(ev_bits[4]), .selftest_fault_in(ev_bits[3]),
    .drive_error_in(ev_bits[2]), .ctrl_error_in(ev_bits[1]), .error_clear_in(ev_bits[0]),
    .status_led_first_out(led1), .status_led_second_out(led2), .status_led_third_out(led3),
    .bus_request_in(req), .bus_grant_in_n_in(gin_n), .bus_grant_out_n_out(gout_n),
    .bus_owned_out(owned), .bus_drive_en_out(drv_en),
    .host_addr_in(addr), .board_select_n_out(sel_n),
    .cmd_word2_in(cmd), .cmd_load_in(load), .drive_select_out(drv));
  bgs_upper_card_model bgs_upper_card_model_i (
    .clock_in(clock_in), .rst_in(rst_in),
    .upper_req_in(upper_req), .bus_grant_n_out(gin_n));

  always #50 clock_in = ~clock_in;

  task wrap_up;
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input string name, input logic [3:0] e, input logic [3:0] s);
    compares++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, e, s);
    end
  endtask

  task nxt;
    @(posedge clock_in);
    #1;
  endtask

  // one-cycle event pulse, returns once the answer has landed
  task ev(input logic [4:0] v);
    @(posedge clock_in);
    ev_bits <= v;
    @(posedge clock_in);
    ev_bits <= 5'h0;
    #1;
  endtask

  always @(posedge clock_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 500)
    begin
      n_mismatch++;
      wrap_up;
    end
  end

  initial
  begin
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    #1;
    chk("leds", {1'b0, LED_TEST}, {1'b0, led3, led2, led1});
    chk("grant out", 4'h1, {3'h0, gout_n});
    chk("select", 4'h1, {3'h0, sel_n});
    chk("drive", DRV_SEL_RESET, drv);
    ev(5'h04);
    chk("leds", {1'b0, LED_TEST}, {1'b0, led3, led2, led1});
    ev(5'h10);
    chk("leds", {1'b0, LED_OK}, {1'b0, led3, led2, led1});
    ev(5'h04);
    chk("leds", {1'b0, LED_DRIVE_ERR}, {1'b0, led3, led2, led1});
    ev(5'h02);
    chk("leds", {1'b0, LED_CTRL_ERR}, {1'b0, led3, led2, led1});
    ev(5'h04);
    chk("leds", {1'b0, LED_CTRL_ERR}, {1'b0, led3, led2, led1});
    ev(5'h01);
    chk("leds", {1'b0, LED_OK}, {1'b0, led3, led2, led1});
    ev(5'h05);
    chk("leds", {1'b0, LED_DRIVE_ERR}, {1'b0, led3, led2, led1});
    foreach (rows[i])
    begin
      @(posedge clock_in);
      addr <= rows[i].addr;
      cmd <= rows[i].cmd;
      load <= 1'b1;
      @(posedge clock_in);
      load <= 1'b0;
      #1;
      chk("select", {3'h0, rows[i].sel_n}, {3'h0, sel_n});
      chk("drive", rows[i].drv, drv);
    end
    @(posedge clock_in);
    cmd <= 16'h0000;
    addr <= 8'h04;
    @(posedge clock_in);
    addr <= 8'h05;
    #1;
    chk("select", 4'h0, {3'h0, sel_n});
    chk("drive", 4'h8, drv);
    nxt;
    chk("select", 4'h1, {3'h0, sel_n});
    chk("grant out", 4'h0, {3'h0, gout_n});
    @(posedge clock_in);
    req <= 1'b1;
    nxt;
    chk("owned", 4'h3, {2'h0, owned, drv_en});
    chk("grant out", 4'h1, {3'h0, gout_n});
    @(posedge clock_in);
    upper_req <= 1'b1;
    nxt;
    nxt;
    chk("owned", 4'h0, {2'h0, owned, drv_en});
    chk("grant out", 4'h1, {3'h0, gout_n});
    @(posedge clock_in);
    req <= 1'b0;
    upper_req <= 1'b0;
    nxt;
    nxt;
    chk("grant out", 4'h0, {3'h0, gout_n});
    @(posedge clock_in);
    rst_in <= 1'b1;
    @(posedge clock_in);
    rst_in <= 1'b0;
    #1;
    chk("leds", {1'b0, LED_TEST}, {1'b0, led3, led2, led1});
    chk("drive", DRV_SEL_RESET, drv);
    chk("owned", 4'h0, {2'h0, owned, drv_en});
    ev(5'h18);
    chk("leds", {1'b0, LED_SELF_FAIL}, {1'b0, led3, led2, led1});
    ev(5'h03);
    chk("leds", {1'b0, LED_SELF_FAIL}, {1'b0, led3, led2, led1});
    wrap_up;
  end
endmodule
